//--- src/cb_uv_pkg.sv
package cb_uv_pkg;
    localparam int NCELL = 14;
    localparam int THR_W = 14;
    localparam int RES_W = 14;
    localparam int ACC_W = 17;
    // One threshold step, in microvolts times ten.
    localparam int THR_STEP_UV_X10 = 3050;
    localparam logic [11:0] ADDR_CTRL = 12'h000;
    localparam logic [11:0] ADDR_SWEN = 12'h004;
    localparam logic [11:0] ADDR_THR = 12'h008;
    localparam logic [11:0] ADDR_STAT = 12'h00C;
    localparam logic [11:0] ADDR_CFG = 12'h010;
    localparam logic [11:0] ADDR_SCAN = 12'h014;
    localparam logic [11:0] ADDR_DLY = 12'h018;
    localparam logic [11:0] ADDR_LOW = 12'h01C;
    localparam logic [11:0] ADDR_ALRT = 12'h020;
    localparam logic [2:0] MODE_OFF = 3'h0;
    localparam logic [2:0] MODE_DISCH = 3'h1;
    localparam logic [1:0] MEAS_CHECK = 2'h3;
    localparam logic [2:0] COEF_UNUSED = 3'h7;
    localparam logic [2:0] COEF_EIGHTH = 3'h0;
    localparam logic [4:0] SEED_SETTLE = 5'h10;
    localparam logic [1:0] OVS_16X = 2'h1;
    localparam logic SCAN_PYRAMID = 1'b1;
    localparam logic [5:0] SCAN_RESET = 6'h00;
    typedef struct packed {
        logic [1:0] oversample_count;
        logic scan_order_select;
        logic [2:0] other;
    } scan_cfg_t;
    typedef struct packed {
        logic [2:0] balance_mode_select;
        logic [1:0] embedded_measure_select;
        logic filter_seed_select;
        logic apply_calibration;
        logic [2:0] filter_coefficient;
    } ctrl_t;
    typedef struct packed {
        logic start;
        logic calibrate;
        logic [1:0] oversample_count;
        logic scan_order_select;
        logic [NCELL-1:0] channels;
    } adc_req_t;
    typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_HALT} seq_t;
    // Calibration spacing per interval code, in measurement cycles.
    function automatic logic [5:0] cal_period(input logic [2:0] code);
        case (code)
            3'h1: cal_period = 6'h02;
            3'h2: cal_period = 6'h04;
            3'h3: cal_period = 6'h08;
            3'h4: cal_period = 6'h0C;
            3'h5: cal_period = 6'h10;
            3'h6: cal_period = 6'h18;
            default: cal_period = 6'h20;
        endcase
    endfunction
endpackage

//--- src/cell_balance_uv_supervisor.sv
// Functional notes
// [RULE1] A cell reaching the threshold has its switch turned off until relaunch.
// [RULE2] Only unipolar, measured, switch-enabled cells may use threshold stop; else exit.
// [RULE3] Exit status bit n flags cell n+1; cleared by mode off or relaunch.
// [RULE4] Threshold stop is active with measurement select 0b11, timers redundant.
// [RULE5] When all enabled cells stopped, all switches off, timer keeps running.
// [RULE6] Threshold is 14 bits, 305 microvolt per step.
// [RULE7] Threshold write loads data, or lowest-cell result when sourcing is on.
// [RULE8] Threshold read returns active value plus lowest-cell sourcing flag.
// [RULE9] Measurements use the mux chain; channels follow switch enables.
// [RULE10] Embedded measurements only when selected and in discharge or automated modes.
// [RULE11] Balancing measurements force 16x oversampling and pyramid order.
// [RULE12] Scan writes during balancing are dropped and raise the reject alert.
// [RULE13] Coefficient 0b111 is replaced by 0b000 during balancing.
// [RULE14] Seed select 0 keeps accumulators and amends them.
// [RULE15] Seed select 1 loads first result; checks start at measurement 17.
// [RULE16] One supervisory measurement follows each even/odd period pair.
// [RULE17] Select 0b0x skips, 0b1x measures, 0b11 checks except in discharge.
// [RULE18] Calibration applied: refreshed or prior coefficients; off: factory defaults.
// [RULE19] Calibration interval acts only when measurement select is 0b1x.
// [RULE20] Interval zero, the reset value, disables calibrations.
// [RULE21] Nonzero interval: first operation calibrates, then periodically.
// [RULE22] After each operation, with calibration applied, sample the range alert.
// [RULE23] Range alert sets fault alert and halts balancing; timer continues.
// [RULE24] Exit status bits read zero after reset.
module cell_balance_uv_supervisor
    import cb_uv_pkg::*;
(
    input wire logic pclk, // APB clock
    input wire logic presetn, // async reset, active low
    input wire logic clk_en, // freezes all state when low
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction
    input wire logic [11:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error
    input wire logic pair_done, // pulse: even/odd period pair ended
    input wire logic adc_done, // pulse: operation complete
    input wire logic [NCELL*RES_W-1:0] adc_result, // per-cell results
    input wire logic calibration_range_alert, // calibration out of range
    input wire logic [NCELL*RES_W-1:0] cell_data, // stored cell registers
    input wire logic [3:0] lowest_cell_pointer, // lowest cell index
    input wire logic [NCELL-1:0] cell_measure_enable, // per-cell measure enable
    input wire logic [NCELL-1:0] cell_polarity, // per-cell bipolar flag
    output adc_req_t adc_req, // request to mux and ADC chain
    output logic use_refreshed_cal, // refreshed calibration coefficients
    output logic use_factory_cal, // factory coefficients
    output logic [NCELL-1:0] switch_on, // per-cell switch permission
    output logic balance_cal_fault_alert, // calibration fault alert
    output logic write_reject_alert, // scan write rejected
    output logic [NCELL*RES_W-1:0] filter_out // filtered values
);
    // Host-visible configuration.
    ctrl_t ctrl_ff;
    logic [NCELL-1:0] balance_switch_enable_ff;

    // [RULE6] 14-bit threshold
    logic [THR_W-1:0] uv_stop_threshold_ff;
    logic threshold_from_lowest_ff;
    logic [NCELL-1:0] uv_exit_status_ff;
    scan_cfg_t scan_ff;
    logic [2:0] calibration_interval_ff;

    // Alert flags; the fault stands until a relaunch, the reject alert until a host clear.
    logic fault_ff;
    logic reject_ff;

    // Operation sequencer and its counters.
    seq_t state_ff;
    logic [5:0] cal_cnt_ff;
    logic first_op_ff;
    logic op_is_cal_ff;
    logic [4:0] seed_cnt_ff;
    logic seed_pending_ff;

    // Accumulators keep three fraction bits so that rounding does not drift the level.
    logic [NCELL*ACC_W-1:0] acc_ff;
    logic [NCELL-1:0] done_ff;

    // Bus decode. The slave never stalls, so an access lands in its first access cycle.
    wire wr = psel && penable && pwrite && clk_en;

    wire rd_addr_ok = paddr == ADDR_CTRL || paddr == ADDR_SWEN || paddr == ADDR_THR
        || paddr == ADDR_STAT || paddr == ADDR_CFG || paddr == ADDR_SCAN
        || paddr == ADDR_DLY || paddr == ADDR_ALRT;

    wire wr_ctrl = wr && paddr == ADDR_CTRL;

    wire wr_thr = wr && paddr == ADDR_THR;

    wire wr_scan = wr && paddr == ADDR_SCAN;

    wire ctrl_t nxt_ctrl = ctrl_t'(pwdata[9:0]);

    // Mode decode. Manual modes leave this supervisor idle.
    wire mode_disch = ctrl_ff.balance_mode_select == MODE_DISCH;

    wire mode_auto = ctrl_ff.balance_mode_select[2];

    // [RULE10] measure gating by mode
    wire meas_mode = mode_disch || mode_auto;

    wire balancing = ctrl_ff.balance_mode_select != MODE_OFF;

    // [RULE17] select decoding
    // A calibration fault blocks every later operation until a relaunch.
    wire measure_on = meas_mode && ctrl_ff.embedded_measure_select[1] && !fault_ff;

    // [RULE4] threshold check only in automated modes
    // Discharge mode still measures for the host but never compares.
    wire check_on = mode_auto && ctrl_ff.embedded_measure_select == MEAS_CHECK;

    // [RULE19] interval used only when measuring
    wire [2:0] eff_interval = ctrl_ff.embedded_measure_select[1]
        ? calibration_interval_ff : 3'h0;

    // [RULE13] unused filter becomes 1/8
    wire [2:0] eff_coef = (meas_mode && ctrl_ff.filter_coefficient == COEF_UNUSED)
        ? COEF_EIGHTH : ctrl_ff.filter_coefficient;

    // A seeded filter is trusted only after sixteen results have settled it.
    wire settled = !ctrl_ff.filter_seed_select || seed_cnt_ff >= SEED_SETTLE;

    // The pointer must stay below the cell count; larger values select no cell.
    wire [RES_W-1:0] low_res = cell_data[lowest_cell_pointer*RES_W +: RES_W];

    // [RULE21] first operation and every period-th one calibrate
    wire nxt_is_cal = eff_interval != 3'h0
        && (first_op_ff || cal_cnt_ff == cal_period(eff_interval) - 6'h01);

    // [RULE22] range alert sampled at completion
    // Without applied calibration the alert is ignored, as results use factory values.
    wire cal_fault = adc_done && state_ff == ST_WAIT && ctrl_ff.apply_calibration
        && calibration_range_alert;

    // A faulted result never reaches the filters.
    wire meas_done = adc_done && state_ff == ST_WAIT && !op_is_cal_ff && !cal_fault;

    // [RULE2] unsupported cells
    wire [NCELL-1:0] unsupported = ~cell_measure_enable | cell_polarity;
    wire [NCELL-1:0] uv_hit;
    logic [NCELL-1:0] nxt_status;

    // Per-cell filter, threshold compare and accumulator.
    genvar i;

    generate
        for (i = 0; i < NCELL; i++) begin : g_cell
            wire [RES_W-1:0] res = adc_result[i*RES_W +: RES_W];
            wire [ACC_W-1:0] acc = acc_ff[i*ACC_W +: ACC_W];
            wire [ACC_W-1:0] res_x8 = {res, 3'h0};
            // Coefficient k+1 eighths of the new sample; 7 passes the sample straight in.
            wire [ACC_W+3:0] mix = ACC_W'(acc) * (4'h7 - {1'b0, eff_coef})
                + ACC_W'(res_x8) * ({1'b0, eff_coef} + 4'h1);
            wire [ACC_W-1:0] nxt_acc = mix[ACC_W+2:3];
            wire [RES_W-1:0] val = nxt_acc[ACC_W-1:3];
            // [RULE1] crossing ends this cell
            assign uv_hit[i] = meas_done && check_on && settled && balance_switch_enable_ff[i]
                && !unsupported[i] && val <= uv_stop_threshold_ff;

            // Cells without a switch enable keep their accumulator untouched.
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    acc_ff[i*ACC_W +: ACC_W] <= '0;
                end else if (clk_en && meas_done && balance_switch_enable_ff[i]) begin
                    // [RULE14] amend, or [RULE15] seed from first result
                    acc_ff[i*ACC_W +: ACC_W] <= seed_pending_ff ? res_x8 : nxt_acc;
                end
            end

            // The host sees the accumulator without its fraction bits.
            assign filter_out[i*RES_W +: RES_W] = acc[ACC_W-1:3];
        end
    endgenerate

    // Status is sticky: only a relaunch or a mode-off write clears it.
    always_comb begin
        nxt_status = uv_exit_status_ff | uv_hit;
        // [RULE2] unsupported cells exit when checking
        if (check_on)
            nxt_status = nxt_status | (unsupported & balance_switch_enable_ff);
        // [RULE3] cleared by mode write
        if (wr_ctrl)
            nxt_status = '0;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_ff <= '0;
            balance_switch_enable_ff <= '0;
            calibration_interval_ff <= 3'h0;
            // [RULE24] cleared at reset
            uv_exit_status_ff <= '0;
        end else if (clk_en) begin
            // Any control write counts as a relaunch of the balancing operation.
            if (wr_ctrl)
                ctrl_ff <= nxt_ctrl;

            if (wr && paddr == ADDR_SWEN)
                balance_switch_enable_ff <= pwdata[NCELL-1:0];
            // [RULE20] reset value disables calibration
            if (wr && paddr == ADDR_DLY)
                calibration_interval_ff <= pwdata[2:0];
            // [RULE3] sticky exit
            uv_exit_status_ff <= nxt_status;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            uv_stop_threshold_ff <= '0;
            threshold_from_lowest_ff <= 1'b0;
        end else if (clk_en && wr_thr) begin
            // The lowest cell is taken from the stored results at the write edge itself.
            // [RULE7] source selection on write
            threshold_from_lowest_ff <= pwdata[15];
            uv_stop_threshold_ff <= pwdata[15] ? low_res : pwdata[THR_W-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            scan_ff <= scan_cfg_t'(SCAN_RESET);
            reject_ff <= 1'b0;
        end else if (clk_en) begin
            // [RULE12] reject scan writes while balancing
            if (wr_scan && !balancing)
                scan_ff <= scan_cfg_t'(pwdata[5:0]);

            // Setting the reject alert wins over a clear in the same cycle.
            if (wr_scan && balancing)
                reject_ff <= 1'b1;
            else if (wr && paddr == ADDR_ALRT && pwdata[0])
                reject_ff <= 1'b0;
        end
    end

    // Sequencer: one operation per even/odd period pair, then wait for its completion.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff <= ST_IDLE;
            fault_ff <= 1'b0;
            cal_cnt_ff <= 6'h00;
            first_op_ff <= 1'b1;
            op_is_cal_ff <= 1'b0;
            seed_cnt_ff <= 5'h00;
            seed_pending_ff <= 1'b0;
        end else if (clk_en) begin
            // A relaunch restarts the calibration count and the filter seeding.
            if (wr_ctrl) begin
                state_ff <= ST_IDLE;
                fault_ff <= 1'b0;
                cal_cnt_ff <= 6'h00;
                first_op_ff <= 1'b1;
                seed_cnt_ff <= 5'h00;
                seed_pending_ff <= nxt_ctrl.filter_seed_select;
            end else begin
                case (state_ff)
                    ST_IDLE: begin
                        // [RULE16] one operation per period pair
                        if (pair_done && measure_on) begin
                            state_ff <= ST_WAIT;
                            op_is_cal_ff <= nxt_is_cal;
                            first_op_ff <= 1'b0;
                            cal_cnt_ff <= nxt_is_cal ? 6'h00 : cal_cnt_ff + 6'h01;
                        end
                    end

                    ST_WAIT: begin
                        if (cal_fault) begin
                            // [RULE23] halt on calibration fault
                            fault_ff <= 1'b1;
                            state_ff <= ST_HALT;
                        end else if (adc_done) begin
                            state_ff <= ST_IDLE;
                            if (!op_is_cal_ff) begin
                                seed_pending_ff <= 1'b0;
                                if (seed_cnt_ff != SEED_SETTLE)
                                    seed_cnt_ff <= seed_cnt_ff + 5'h01;
                            end
                        end
                    end

                    // Only a control write leaves the halt; the elapsed timer runs on outside.
                    ST_HALT: state_ff <= ST_HALT;
                    default: state_ff <= ST_IDLE;
                endcase
            end
        end
    end

    // [RULE5] all enabled cells done turns all off
    // The exit status doubles as the per-cell done mark.
    assign done_ff = uv_exit_status_ff;

    wire all_done = check_on && balance_switch_enable_ff != '0
        && (balance_switch_enable_ff & ~done_ff) == '0;

    // [RULE1] per-cell idle after exit
    // This is a permission only; the even/odd switch timing lives outside the block.
    assign switch_on = (fault_ff || all_done || !balancing) ? '0
        : balance_switch_enable_ff & ~done_ff;

    // [RULE9] channels follow switch enables; [RULE11] forced scan settings
    // A frozen clock enable must not launch an operation the sequencer cannot follow.
    assign adc_req.start = clk_en && state_ff == ST_IDLE && pair_done && measure_on && !wr_ctrl;

    assign adc_req.calibrate = nxt_is_cal;

    // The host scan configuration is not consulted for these two fields.
    assign adc_req.oversample_count = OVS_16X;
    assign adc_req.scan_order_select = SCAN_PYRAMID;

    assign adc_req.channels = balance_switch_enable_ff;

    // [RULE18] coefficient choice
    // Calibrations still run without applied calibration; only their use is dropped.
    assign use_factory_cal = !ctrl_ff.apply_calibration;

    assign use_refreshed_cal = ctrl_ff.apply_calibration && eff_interval != 3'h0;

    assign balance_cal_fault_alert = fault_ff;

    assign write_reject_alert = reject_ff;

    // No wait states: every access completes in its first access cycle.
    assign pready = 1'b1;

    // Unmapped addresses raise an error, drop writes and read as zero.
    assign pslverr = psel && penable && !rd_addr_ok;

    always_comb begin
        prdata = 32'h0000_0000;
        case (paddr)
            ADDR_CTRL: prdata = {22'h0, ctrl_ff};
            ADDR_SWEN: prdata = {18'h0, balance_switch_enable_ff};
            // [RULE8] active threshold with its source flag
            ADDR_THR: prdata = {16'h0, threshold_from_lowest_ff, 1'b0, uv_stop_threshold_ff};
            ADDR_STAT: prdata = {18'h0, uv_exit_status_ff};
            ADDR_SCAN: prdata = {26'h0, scan_ff};
            ADDR_DLY: prdata = {29'h0, calibration_interval_ff};
            ADDR_ALRT: prdata = {30'h0, fault_ff, reject_ff};
            default: prdata = 32'h0000_0000;
        endcase
    end
endmodule

//--- verification/cell_balance_uv_supervisor_asserts.sv
module cell_balance_uv_supervisor_asserts
    import cb_uv_pkg::*;
(
    input wire logic pclk, // clock
    input wire logic presetn, // reset, active low
    input wire logic clk_en, // state enable
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction
    input wire logic [11:0] paddr, // APB address
    input wire logic [31:0] pwdata, // APB write data
    input wire logic [31:0] prdata, // APB read data
    input wire logic pair_done, // period pair ended
    input wire logic adc_done, // operation complete
    input wire logic calibration_range_alert, // calibration range
    input wire logic [NCELL*RES_W-1:0] cell_data, // stored results
    input wire logic [3:0] lowest_cell_pointer, // lowest cell
    input wire adc_req_t adc_req, // ADC request
    input wire logic use_factory_cal, // factory coefficients
    input wire logic [NCELL-1:0] switch_on, // switch permission
    input wire logic balance_cal_fault_alert, // calibration fault
    input wire logic write_reject_alert // scan write rejected
);
    logic [9:0] ctrl_ff;
    logic [2:0] dly_ff;
    logic [13:0] thr_ff;
    logic low_ff;
    logic launched_ff;
    logic [13:0] nxt_thr;
    wire acc = psel && penable && clk_en;
    wire wr = acc && pwrite;
    wire rd = acc && !pwrite;
    wire active = ctrl_ff[9:7] == MODE_DISCH || ctrl_ff[9];
    // The mirror samples the lowest cell at the write, as the block must.
    assign nxt_thr = pwdata[15] ? cell_data[lowest_cell_pointer*RES_W +: RES_W] : pwdata[13:0];
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_ff <= '0;
            dly_ff <= '0;
            thr_ff <= '0;
            low_ff <= 1'b0;
            launched_ff <= 1'b0;
        end else if (wr) begin
            if (paddr == ADDR_CTRL) ctrl_ff <= pwdata[9:0];
            if (paddr == ADDR_CTRL) launched_ff <= 1'b1;
            if (paddr == ADDR_DLY) dly_ff <= pwdata[2:0];
            if (paddr == ADDR_THR) thr_ff <= nxt_thr;
            if (paddr == ADDR_THR) low_ff <= pwdata[15];
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_start_pair; adc_req.start |-> pair_done && clk_en; endproperty
    a_start_pair: assert property (p_start_pair) else $error("start without pair");
    property p_forced; adc_req.start |->
        adc_req.oversample_count == OVS_16X && adc_req.scan_order_select == SCAN_PYRAMID; endproperty
    a_forced: assert property (p_forced) else $error("scan not forced");
    property p_start_mode; adc_req.start |-> ctrl_ff[6] && active; endproperty
    a_start_mode: assert property (p_start_mode) else $error("start in wrong mode");
    property p_measure; pair_done && clk_en && ctrl_ff[6] && active && !balance_cal_fault_alert
        |-> adc_req.start; endproperty
    a_measure: assert property (p_measure) else $error("measurement missed");
    property p_cal_off; adc_req.start && dly_ff == 3'h0 |-> !adc_req.calibrate; endproperty
    a_cal_off: assert property (p_cal_off) else $error("calibration while off");
    property p_stat_reset; rd && paddr == ADDR_STAT && !launched_ff |-> prdata == 32'h0; endproperty
    a_stat_reset: assert property (p_stat_reset) else $error("status not clear");
    property p_thr_read; rd && paddr == ADDR_THR |->
        prdata[13:0] == thr_ff && prdata[15] == low_ff; endproperty
    a_thr_read: assert property (p_thr_read) else $error("threshold readback");
    property p_reject; wr && paddr == ADDR_SCAN && ctrl_ff[9:7] != MODE_OFF
        |=> write_reject_alert; endproperty
    a_reject: assert property (p_reject) else $error("reject alert missing");
    property p_fault; adc_done && clk_en && calibration_range_alert && ctrl_ff[3] && ctrl_ff[6]
        && active && !(wr && paddr == ADDR_CTRL) |=> balance_cal_fault_alert && switch_on == '0;
    endproperty
    a_fault: assert property (p_fault) else $error("fault not halting");
    property p_factory; use_factory_cal == !ctrl_ff[3]; endproperty
    a_factory: assert property (p_factory) else $error("factory selection");
endmodule
bind cell_balance_uv_supervisor cell_balance_uv_supervisor_asserts u_chk (.pclk, .presetn,
    .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pair_done, .adc_done,
    .calibration_range_alert, .cell_data, .lowest_cell_pointer, .adc_req, .use_factory_cal,
    .switch_on, .balance_cal_fault_alert, .write_reject_alert);

//--- verification/cell_balance_uv_supervisor_tb_top.sv
module cell_balance_uv_supervisor_tb_top
    import cb_uv_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic pclk, presetn, clk_en, psel, penable, pwrite, pair_done, adc_done, pready, pslverr;
    logic calibration_range_alert, use_refreshed_cal, use_factory_cal, write_reject_alert;
    logic balance_cal_fault_alert;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd_q;
    logic err_q;
    logic [NCELL*RES_W-1:0] adc_result, cell_data, filter_out;
    logic [3:0] lowest_cell_pointer;
    logic [NCELL-1:0] cell_measure_enable, cell_polarity, switch_on;
    adc_req_t adc_req;
    int errors, comparisons, cycles;
    cell_balance_uv_supervisor dut (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .pair_done, .adc_done, .adc_result,
        .calibration_range_alert, .cell_data, .lowest_cell_pointer, .cell_measure_enable,
        .cell_polarity, .adc_req, .use_refreshed_cal, .use_factory_cal, .switch_on,
        .balance_cal_fault_alert, .write_reject_alert, .filter_out);
    always #25 pclk = ~pclk;
    task automatic report_and_stop();
        $display("errors=%0d comparisons=%0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 5000) begin
            errors++;
            report_and_stop();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Request is held until pready is seen, so a slower slave still works.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd_q = prdata;
        err_q = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd_q & m, e);
    endtask
    task automatic pair(input logic es, input logic ec);
        @(posedge pclk);
        pair_done <= 1'b1;
        @(negedge pclk);
        chk(32'(adc_req.start), 32'(es));
        if (es) chk(32'({adc_req.oversample_count, adc_req.scan_order_select, adc_req.calibrate,
            adc_req.channels}), 32'({OVS_16X, SCAN_PYRAMID, ec, 14'h0007}));
        @(posedge pclk);
        pair_done <= 1'b0;
    endtask
    task automatic adc(input logic [13:0] r0, input logic [13:0] r1, input logic al);
        @(posedge pclk);
        adc_result[41:0] <= {r0, r1, r0};
        calibration_range_alert <= al;
        adc_done <= 1'b1;
        @(posedge pclk);
        adc_done <= 1'b0;
        repeat (2) @(posedge pclk);
    endtask
    task automatic t_reset_thr();
        rd(ADDR_STAT, 32'h3FFF, 32'h0);
        apb(1'b0, 12'h01C, 32'h0);
        chk(32'(err_q), 32'h1);
        wr(ADDR_THR, 32'h1ABC);
        rd(ADDR_THR, 32'hBFFF, 32'h1ABC);
        cell_data[5*RES_W +: RES_W] <= 14'h0123;
        lowest_cell_pointer <= 4'h5;
        wr(ADDR_THR, 32'h8555);
        rd(ADDR_THR, 32'hBFFF, 32'h8123);
        wr(ADDR_THR, 32'h1000);
    endtask
    task automatic t_reject();
        wr(ADDR_CTRL, 32'h270);
        wr(ADDR_SCAN, 32'h3F);
        @(negedge pclk);
        chk(32'(write_reject_alert), 32'h1);
        rd(ADDR_SCAN, 32'h3F, 32'h0);
        rd(ADDR_ALRT, 32'h1, 32'h1);
        wr(ADDR_ALRT, 32'h1);
        rd(ADDR_ALRT, 32'h1, 32'h0);
        wr(ADDR_CTRL, 32'h0);
        wr(ADDR_SCAN, 32'h05);
        rd(ADDR_SCAN, 32'h3F, 32'h05);
    endtask
    task automatic t_measure();
        cell_polarity <= 14'h0004;
        wr(ADDR_SWEN, 32'h7);
        wr(ADDR_CTRL, 32'h270);
        for (int i = 1; i <= 17; i++) begin
            pair(1'b1, 1'b0);
            adc(14'h0800, 14'h1100, 1'b0);
            if (i == 1) chk(32'(filter_out[13:0]), 32'h0800);
            if (i == 16) rd(ADDR_STAT, 32'h3, 32'h0);
        end
        rd(ADDR_STAT, 32'h3FFF, 32'h5);
        chk(32'(switch_on), 32'h2);
        pair(1'b1, 1'b0);
        adc(14'h0000, 14'h0000, 1'b0);
        rd(ADDR_STAT, 32'h3FFF, 32'h7);
        chk(32'(switch_on), 32'h0);
        wr(ADDR_CTRL, 32'h0);
        rd(ADDR_STAT, 32'h3FFF, 32'h0);
        cell_polarity <= 14'h0000;
    endtask
    task automatic t_cal();
        wr(ADDR_DLY, 32'h1);
        wr(ADDR_CTRL, 32'h160);
        pair(1'b0, 1'b0);
        wr(ADDR_CTRL, 32'h0CF);
        @(negedge pclk);
        chk({30'h0, use_refreshed_cal, use_factory_cal}, 32'h2);
        for (int i = 0; i < 3; i++) begin
            pair(1'b1, i[0] == 1'b0);
            adc(14'h0800, 14'h0800, i == 2);
        end
        rd(ADDR_ALRT, 32'h2, 32'h2);
        chk(32'(balance_cal_fault_alert), 32'h1);
        chk(32'(filter_out[27:14]), 32'h0E04);
        chk(32'(switch_on), 32'h0);
        pair(1'b0, 1'b0);
        calibration_range_alert <= 1'b0;
        wr(ADDR_CTRL, 32'h0);
    endtask
    initial begin
        {psel, penable, pwrite, pair_done, adc_done, calibration_range_alert} = '0;
        {paddr, pwdata, adc_result, cell_data, lowest_cell_pointer, cell_polarity} = '0;
        cell_measure_enable = '1;
        clk_en = 1'b1;
        pclk = 1'b0;
        presetn = 1'b0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        t_reset_thr();
        t_reject();
        t_measure();
        t_cal();
        report_and_stop();
    end
endmodule
